// ---- verilog/amp_access_check.sv ----
module amp_access_check
   import amp_pkg::*;
(
   // Clock and reset
   input  wire logic                      clk_sys,
   input  wire logic                      resetn,
   // Map setup
   input  wire logic                      map_load,
   input  wire logic                      map_ispace,
   input  wire amp_pkg::amp_mode_t        map_mode,
   input  wire logic [AMP_PAGE_W-1:0]     map_page,
   input  wire logic [AMP_REL_W-1:0]      map_rel,
   input  wire amp_pkg::amp_acc_t         map_acc,
   // Transfer request
   input  wire amp_pkg::amp_xfer_t        xfer_type,
   input  wire logic [AMP_VA_W-1:0]       xfer_va,
   // Transfer answer
   output logic                           xfer_ok,
   output logic                           xfer_abort,
   output logic [AMP_PA_W-1:0]            xfer_pa,
   output logic                           xfer_ispace,
   // Privileged instruction request
   input  wire amp_pkg::amp_op_t          op,
   input  wire logic [15:0]               op_data,
   // Privileged effects
   output logic                           halt_stop,
   output logic                           halt_trap,
   output logic                           io_reset,
   output logic [15:0]                    processor_status_word,
   // Stack linkage
   input  wire logic                      stk_push,
   input  wire logic                      stk_pop,
   input  wire logic                      stk_load,
   input  wire logic [15:0]               stk_wdata,
   output logic [15:0]                    stk_ptr,
   // Mode view
   output logic [1:0]                     cur_mode,
   output logic [1:0]                     prev_mode
);
   import amp_pkg::*;

   // ************************************************************
   // Mode decode
   // ************************************************************
   logic [15:0] psw_q;
   logic [15:0] psw_d;
   amp_mode_t   mode_cur;
   amp_mode_t   mode_prv;

   assign mode_cur = amp_mode_t'(psw_q[AMP_CUR_HI:AMP_CUR_LO]);
   assign mode_prv = amp_mode_t'(psw_q[AMP_PRV_HI:AMP_PRV_LO]);

   // ************************************************************
   // Maps: one I and one D map per mode
   // ************************************************************
   logic [AMP_PAGE_W-1:0] look_page;
   logic [AMP_REL_W-1:0]  rel_i [AMP_MODES];
   logic [AMP_REL_W-1:0]  rel_dm [AMP_MODES];
   amp_acc_t              acc_i [AMP_MODES];
   amp_acc_t              acc_dm [AMP_MODES];
   logic [AMP_MODES-1:0]  load_imap;
   logic [AMP_MODES-1:0]  load_dmap;

   assign look_page = xfer_va[AMP_VA_W-1:AMP_PAGE_LSB];

   // Separate I and D loads keep the two maps independent
   genvar g;
   generate
      for (g = 0; g < AMP_MODES; g++)
      begin : g_map
         // Only the addressed space of the addressed mode takes the entry
         assign load_imap[g] = map_load && map_ispace && (map_mode == amp_mode_t'(g));
         assign load_dmap[g] = map_load && !map_ispace && (map_mode == amp_mode_t'(g));

         amp_page_map u_imap
         (
            .clk_sys   (clk_sys),
            .resetn    (resetn),
            .load      (load_imap[g]),
            .load_page (map_page),
            .load_rel  (map_rel),
            .load_acc  (map_acc),
            .look_page (look_page),
            .look_rel  (rel_i[g]),
            .look_acc  (acc_i[g])
         );

         amp_page_map u_dmap
         (
            .clk_sys   (clk_sys),
            .resetn    (resetn),
            .load      (load_dmap[g]),
            .load_page (map_page),
            .load_rel  (map_rel),
            .load_acc  (map_acc),
            .look_page (look_page),
            .look_rel  (rel_dm[g]),
            .look_acc  (acc_dm[g])
         );
      end
   endgenerate

   // ************************************************************
   // Access check
   // ************************************************************
   logic                  use_i;
   logic [AMP_REL_W-1:0]  sel_rel;
   amp_acc_t              sel_acc;
   logic                  deny;
   logic [AMP_PA_W-1:0]   pa_calc;

   logic                  ok_q;
   logic                  ok_d;
   logic                  ab_q;
   logic                  ab_d;
   logic [AMP_PA_W-1:0]   pa_q;
   logic [AMP_PA_W-1:0]   pa_d;
   logic                  isp_q;
   logic                  isp_d;

   always_comb
   begin
      use_i   = (xfer_type == AMP_XF_FETCH);
      sel_rel = use_i ? rel_i[mode_cur] : rel_dm[mode_cur];
      sel_acc = use_i ? acc_i[mode_cur] : acc_dm[mode_cur];
      // Execute-only needs no code: data never looks in the I map
      unique case (sel_acc)
         AMP_ACC_RW:     deny = 1'b0;
         AMP_ACC_RO:     deny = (xfer_type == AMP_XF_WRITE);
         AMP_ACC_NONRES: deny = 1'b1;
         AMP_ACC_RSVD:   deny = 1'b1;
      endcase
      pa_calc = AMP_PA_W'({sel_rel, {AMP_REL_SHIFT{1'b0}}})
              + AMP_PA_W'(xfer_va[AMP_OFF_W-1:0]);
      ok_d  = 1'b0;
      ab_d  = 1'b0;
      pa_d  = pa_q;
      isp_d = isp_q;
      if (xfer_type != AMP_XF_IDLE)
      begin
         // Abort carries no address so memory is never touched
         ok_d  = !deny;
         ab_d  = deny;
         pa_d  = deny ? '0 : pa_calc;
         isp_d = use_i;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         ok_q  <= 1'b0;
         ab_q  <= 1'b0;
         pa_q  <= '0;
         isp_q <= 1'b0;
      end
      else
      begin
         ok_q  <= ok_d;
         ab_q  <= ab_d;
         pa_q  <= pa_d;
         isp_q <= isp_d;
      end
   end

   assign xfer_ok     = ok_q;
   assign xfer_abort  = ab_q;
   assign xfer_pa     = pa_q;
   assign xfer_ispace = isp_q;

   // ************************************************************
   // Privileged instructions
   // ************************************************************
   logic kernel;
   logic stop_q;
   logic stop_d;
   logic trap_q;
   logic trap_d;
   logic iorst_q;
   logic iorst_d;

   assign kernel = (mode_cur == AMP_MODE_KERNEL);

   always_comb
   begin
      psw_d   = psw_q;
      stop_d  = 1'b0;
      trap_d  = 1'b0;
      iorst_d = 1'b0;
      unique case (op)
         AMP_OP_HALT:
         begin
            stop_d = kernel;
            trap_d = !kernel;
         end
         AMP_OP_RESET:
            iorst_d = kernel;
         AMP_OP_SET_PRI:
            if (kernel)
               psw_d[AMP_PRI_HI:AMP_PRI_LO] = op_data[AMP_PRI_HI:AMP_PRI_LO];
         AMP_OP_PSW:
            if (kernel)
               psw_d = op_data;
         default:
            psw_d = psw_q;
      endcase
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         psw_q   <= AMP_PSW_RST;
         stop_q  <= 1'b0;
         trap_q  <= 1'b0;
         iorst_q <= 1'b0;
      end
      else
      begin
         psw_q   <= psw_d;
         stop_q  <= stop_d;
         trap_q  <= trap_d;
         iorst_q <= iorst_d;
      end
   end

   assign halt_stop             = stop_q;
   assign halt_trap             = trap_q;
   assign io_reset              = iorst_q;
   assign processor_status_word = psw_q;

   // ************************************************************
   // Stack: pushes, pops and loads all use the current mode's pointer
   // ************************************************************
   logic [15:0] sp_cur;
   logic [15:0] sp_q;
   logic [15:0] sp_d;

   amp_stack_sel u_stack
   (
      .clk_sys  (clk_sys),
      .resetn   (resetn),
      .mode     (mode_cur),
      .push     (stk_push),
      .pop      (stk_pop),
      .sp_load  (stk_load),
      .sp_wdata (stk_wdata),
      .sp_cur   (sp_cur)
   );

   // Registered copy lags the live pointer by one cycle, so the
   // pointer output comes from a flop like every other output
   always_comb
   begin
      sp_d = sp_cur;
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         sp_q <= AMP_SP_RST;
      else
         sp_q <= sp_d;
   end

   assign stk_ptr   = sp_q;
   assign cur_mode  = psw_q[AMP_CUR_HI:AMP_CUR_LO];
   assign prev_mode = psw_q[AMP_PRV_HI:AMP_PRV_LO];

endmodule : amp_access_check

// ---- verilog/amp_pkg.sv ----
package amp_pkg;

   // ************************************************************
   // Widths and layout
   // ************************************************************
   localparam int AMP_PAGES     = 8;
   localparam int AMP_PAGE_W    = 3;
   localparam int AMP_VA_W      = 16;
   localparam int AMP_PA_W      = 22;
   localparam int AMP_REL_W     = 16;
   localparam int AMP_ACC_W     = 2;
   localparam int AMP_PAGE_LSB  = 13;
   localparam int AMP_OFF_W     = 13;
   localparam int AMP_REL_SHIFT = 6;
   localparam int AMP_CUR_HI    = 15;
   localparam int AMP_CUR_LO    = 14;
   localparam int AMP_PRV_HI    = 13;
   localparam int AMP_PRV_LO    = 12;
   localparam int AMP_PRI_HI    = 7;
   localparam int AMP_PRI_LO    = 5;
   localparam int AMP_MODES     = 4;

   localparam logic [15:0] AMP_PSW_RST = 16'h0000;
   localparam logic [15:0] AMP_SP_RST  = 16'h0000;
   localparam logic [15:0] AMP_SP_STEP = 16'h0002;

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [1:0]
   {
      AMP_MODE_KERNEL = 2'b00,
      AMP_MODE_SUPER  = 2'b01,
      AMP_MODE_ILLEG  = 2'b10,
      AMP_MODE_USER   = 2'b11
   } amp_mode_t;

   typedef enum logic [1:0]
   {
      AMP_ACC_NONRES = 2'b00,
      AMP_ACC_RO     = 2'b01,
      AMP_ACC_RSVD   = 2'b10,
      AMP_ACC_RW     = 2'b11
   } amp_acc_t;

   typedef enum logic [2:0]
   {
      AMP_OP_NONE    = 3'b000,
      AMP_OP_HALT    = 3'b001,
      AMP_OP_RESET   = 3'b010,
      AMP_OP_SET_PRI = 3'b011,
      AMP_OP_PSW     = 3'b100
   } amp_op_t;

   typedef enum logic [1:0]
   {
      AMP_XF_IDLE  = 2'b00,
      AMP_XF_FETCH = 2'b01,
      AMP_XF_READ  = 2'b10,
      AMP_XF_WRITE = 2'b11
   } amp_xfer_t;

endpackage : amp_pkg

// ---- verilog/amp_page_map.sv ----
// One address space map: per page relocation and access code
module amp_page_map
   import amp_pkg::*;
(
   // Clock and reset
   input  wire logic                      clk_sys,
   input  wire logic                      resetn,
   // Load port
   input  wire logic                      load,
   input  wire logic [AMP_PAGE_W-1:0]     load_page,
   input  wire logic [AMP_REL_W-1:0]      load_rel,
   input  wire amp_pkg::amp_acc_t         load_acc,
   // Lookup
   input  wire logic [AMP_PAGE_W-1:0]     look_page,
   output logic      [AMP_REL_W-1:0]      look_rel,
   output amp_pkg::amp_acc_t              look_acc
);
   import amp_pkg::*;

   logic     [AMP_REL_W-1:0] rel_q [AMP_PAGES];
   amp_acc_t                 acc_q [AMP_PAGES];
   logic     [AMP_REL_W-1:0] rel_d [AMP_PAGES];
   amp_acc_t                 acc_d [AMP_PAGES];

   // Access code sits beside relocation in each page register
   genvar g;
   generate
      for (g = 0; g < AMP_PAGES; g++)
      begin : g_page
         always_comb
         begin
            rel_d[g] = rel_q[g];
            acc_d[g] = acc_q[g];
            if (load && (load_page == AMP_PAGE_W'(g)))
            begin
               rel_d[g] = load_rel;
               acc_d[g] = load_acc;
            end
         end

         // Pages come up non-resident so nothing maps before setup
         always_ff @(posedge clk_sys or negedge resetn)
         begin
            if (!resetn)
            begin
               rel_q[g] <= '0;
               acc_q[g] <= AMP_ACC_NONRES;
            end
            else
            begin
               rel_q[g] <= rel_d[g];
               acc_q[g] <= acc_d[g];
            end
         end
      end
   endgenerate

   assign look_rel = rel_q[look_page];
   assign look_acc = acc_q[look_page];

endmodule : amp_page_map

// ---- verilog/amp_stack_sel.sv ----
// Per mode stack pointers with push and pop
module amp_stack_sel
   import amp_pkg::*;
(
   // Clock and reset
   input  wire logic                      clk_sys,
   input  wire logic                      resetn,
   // Control
   input  wire amp_pkg::amp_mode_t        mode,
   input  wire logic                      push,
   input  wire logic                      pop,
   input  wire logic                      sp_load,
   input  wire logic [15:0]               sp_wdata,
   // Active pointer
   output logic      [15:0]               sp_cur
);
   import amp_pkg::*;

   logic [15:0] sp_q [AMP_MODES];
   logic [15:0] sp_d [AMP_MODES];

   genvar g;
   generate
      for (g = 0; g < AMP_MODES; g++)
      begin : g_sp
         always_comb
         begin
            sp_d[g] = sp_q[g];
            if (mode == amp_mode_t'(g))
            begin
               // Stack grows down; pointer always names the newest entry
               if (sp_load)
                  sp_d[g] = sp_wdata;
               else if (push && !pop)
                  sp_d[g] = sp_q[g] - AMP_SP_STEP;
               else if (pop && !push)
                  sp_d[g] = sp_q[g] + AMP_SP_STEP;
            end
         end

         always_ff @(posedge clk_sys or negedge resetn)
         begin
            if (!resetn)
               sp_q[g] <= AMP_SP_RST;
            else
               sp_q[g] <= sp_d[g];
         end
      end
   endgenerate

   assign sp_cur = sp_q[mode];

endmodule : amp_stack_sel

// ---- tb/amp_access_check_assertions.sv ----
module amp_access_check_assertions
   import amp_pkg::*;
(
   // Clock and reset
   input wire logic                clk_sys,
   input wire logic                resetn,
   // Transfers
   input wire amp_pkg::amp_xfer_t  xfer_type,
   input wire logic                xfer_ok,
   input wire logic                xfer_abort,
   input wire logic [AMP_PA_W-1:0] xfer_pa,
   input wire logic                xfer_ispace,
   // Privileged operations
   input wire amp_pkg::amp_op_t    op,
   input wire logic                halt_stop,
   input wire logic                halt_trap,
   input wire logic                io_reset,
   input wire logic [15:0]         processor_status_word,
   input wire logic [1:0]          cur_mode,
   input wire logic [1:0]          prev_mode,
   // Stack
   input wire logic                stk_push,
   input wire logic                stk_pop,
   input wire logic                stk_load,
   input wire logic [15:0]         stk_ptr
);
   timeunit 1ns;
   timeprecision 1ns;

   // ************************************************************
   // Properties
   // ************************************************************
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);

   ans_excl_a: assert property (!(xfer_ok && xfer_abort))
      else $error("transfer accepted and refused together");
   ans_one_a: assert property (xfer_type != AMP_XF_IDLE |=> xfer_ok != xfer_abort)
      else $error("transfer got no single answer");
   idle_quiet_a: assert property (xfer_type == AMP_XF_IDLE |=>
      !xfer_ok && !xfer_abort) else $error("answer without a transfer");
   abort_pa_a: assert property (xfer_abort |-> xfer_pa == '0)
      else $error("refused transfer leaks an address");
   space_sel_a: assert property (xfer_type != AMP_XF_IDLE |=>
      xfer_ispace == ($past(xfer_type) == AMP_XF_FETCH)) else $error("wrong map space");
   halt_kern_a: assert property (op == AMP_OP_HALT && cur_mode == 2'b00 |=>
      halt_stop && !halt_trap) else $error("kernel halt did not stop");
   halt_trap_a: assert property (op == AMP_OP_HALT && cur_mode != 2'b00 |=>
      halt_trap && !halt_stop) else $error("halt outside kernel did not trap");
   io_reset_a: assert property (io_reset |->
      $past(op) == AMP_OP_RESET && $past(cur_mode) == 2'b00) else $error("stray device reset");
   psw_guard_a: assert property (cur_mode != 2'b00 &&
      op inside {AMP_OP_RESET, AMP_OP_SET_PRI, AMP_OP_PSW} |=> $stable(processor_status_word))
      else $error("status word changed outside kernel");
   psw_kernel_a: assert property (!$stable(processor_status_word) |->
      $past(op) inside {AMP_OP_SET_PRI, AMP_OP_PSW} && $past(cur_mode) == 2'b00)
      else $error("status word changed without a kernel write");
   mode_view_a: assert property (cur_mode == processor_status_word[15:14] &&
      prev_mode == processor_status_word[13:12]) else $error("mode view mismatch");
   // Mode must hold so both samples show the same pointer
   push_step_a: assert property (stk_push && !stk_pop && !stk_load ##1
      $stable(cur_mode) |=> stk_ptr == $past(stk_ptr) - AMP_SP_STEP)
      else $error("push did not step pointer");

   abort_c: cover property (xfer_abort);
   trap_c: cover property (halt_trap);
   push_c: cover property (stk_push);
   reset_c: cover property (io_reset);
endmodule : amp_access_check_assertions

bind amp_access_check amp_access_check_assertions u_chk
(
   .clk_sys(clk_sys), .resetn(resetn), .xfer_type(xfer_type), .xfer_ok(xfer_ok),
   .xfer_abort(xfer_abort), .xfer_pa(xfer_pa), .xfer_ispace(xfer_ispace), .op(op),
   .halt_stop(halt_stop), .halt_trap(halt_trap), .io_reset(io_reset),
   .processor_status_word(processor_status_word), .cur_mode(cur_mode),
   .prev_mode(prev_mode), .stk_push(stk_push), .stk_pop(stk_pop), .stk_load(stk_load),
   .stk_ptr(stk_ptr)
);

// ---- tb/amp_seq_model.sv ----
// Sequencer side: every request stands for exactly one edge
module amp_seq_model
   import amp_pkg::*;
(
   // Clock
   input  wire logic          clk_sys,
   // Map setup
   output logic               map_load,
   output logic               map_ispace,
   output amp_pkg::amp_mode_t map_mode,
   output logic [2:0]         map_page,
   output logic [15:0]        map_rel,
   output amp_pkg::amp_acc_t  map_acc,
   // Requests
   output amp_pkg::amp_xfer_t xfer_type,
   output logic [15:0]        xfer_va,
   output amp_pkg::amp_op_t   op,
   output logic [15:0]        op_data,
   output logic               stk_push,
   output logic               stk_pop,
   output logic               stk_load,
   output logic [15:0]        stk_wdata
);
   timeunit 1ns;
   timeprecision 1ns;

   initial
   begin
      {map_load, map_ispace, map_page, map_rel, xfer_va, op_data} = '0;
      {stk_push, stk_pop, stk_load, stk_wdata} = '0;
      map_mode = AMP_MODE_KERNEL;
      map_acc = AMP_ACC_NONRES;
      xfer_type = AMP_XF_IDLE;
      op = AMP_OP_NONE;
   end

   task automatic map_set(input logic i, input amp_mode_t m, input logic [2:0] pg,
                          input logic [15:0] rel, input amp_acc_t acc);
      @(posedge clk_sys);
      {map_load, map_ispace, map_page, map_rel} <= {1'b1, i, pg, rel};
      map_mode <= m;
      map_acc <= acc;
      @(posedge clk_sys);
      map_load <= 1'b0;
   endtask : map_set

   task automatic xfer(input amp_xfer_t t, input logic [15:0] va);
      @(posedge clk_sys);
      xfer_type <= t;
      xfer_va <= va;
      @(posedge clk_sys);
      xfer_type <= AMP_XF_IDLE;
   endtask : xfer

   task automatic instr(input amp_op_t o, input logic [15:0] d);
      @(posedge clk_sys);
      op <= o;
      op_data <= d;
      @(posedge clk_sys);
      op <= AMP_OP_NONE;
   endtask : instr

   task automatic stk(input logic [2:0] ppl, input logic [15:0] d);
      @(posedge clk_sys);
      {stk_push, stk_pop, stk_load} <= ppl;
      stk_wdata <= d;
      @(posedge clk_sys);
      {stk_push, stk_pop, stk_load} <= 3'b000;
   endtask : stk
endmodule : amp_seq_model

// ---- tb/testbench.sv ----
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import amp_pkg::*;

   logic        clk_sys = 1'b0;
   logic        resetn = 1'b0;
   int          error_cnt = 0;
   int          compares = 0;
   logic        map_load, map_ispace, stk_push, stk_pop, stk_load, xfer_ok, xfer_abort;
   logic        xfer_ispace, halt_stop, halt_trap, io_reset;
   amp_mode_t   map_mode;
   amp_acc_t    map_acc;
   amp_xfer_t   xfer_type;
   amp_op_t     op;
   logic [2:0]  map_page;
   logic [15:0] map_rel, xfer_va, op_data, stk_wdata, psw, stk_ptr;
   logic [21:0] xfer_pa;
   logic [1:0]  cur_mode, prev_mode;

   always #5 clk_sys = ~clk_sys;

   amp_seq_model u_seq (.clk_sys(clk_sys), .map_load(map_load), .map_ispace(map_ispace),
      .map_mode(map_mode), .map_page(map_page), .map_rel(map_rel), .map_acc(map_acc),
      .xfer_type(xfer_type), .xfer_va(xfer_va), .op(op), .op_data(op_data),
      .stk_push(stk_push), .stk_pop(stk_pop), .stk_load(stk_load), .stk_wdata(stk_wdata));

   amp_access_check u_dut (.clk_sys(clk_sys), .resetn(resetn), .map_load(map_load),
      .map_ispace(map_ispace), .map_mode(map_mode), .map_page(map_page),
      .map_rel(map_rel), .map_acc(map_acc), .xfer_type(xfer_type), .xfer_va(xfer_va),
      .xfer_ok(xfer_ok), .xfer_abort(xfer_abort), .xfer_pa(xfer_pa),
      .xfer_ispace(xfer_ispace), .op(op), .op_data(op_data), .halt_stop(halt_stop),
      .halt_trap(halt_trap), .io_reset(io_reset), .processor_status_word(psw),
      .stk_push(stk_push), .stk_pop(stk_pop), .stk_load(stk_load),
      .stk_wdata(stk_wdata), .stk_ptr(stk_ptr), .cur_mode(cur_mode),
      .prev_mode(prev_mode));

   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic tally_and_finish;
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : tally_and_finish

   task automatic do_reset;
      @(posedge clk_sys);
      resetn <= 1'b0;
      repeat (4) @(posedge clk_sys);
      resetn <= 1'b1;
   endtask : do_reset

   // Answer lands at the edge that ends the request
   task automatic xf(input amp_xfer_t t, input logic [15:0] va, input logic [23:0] exp);
      u_seq.xfer(t, va);
      #1 chk({xfer_ok, xfer_ispace, xfer_pa}, exp);
      chk({23'h00_0000, xfer_abort}, {23'h00_0000, ~exp[23]});
   endtask : xf

   task automatic pr(input amp_op_t o, input logic [15:0] d, input logic [23:0] exp);
      u_seq.instr(o, d);
      #1 chk({1'b0, halt_stop, halt_trap, io_reset, cur_mode, prev_mode, psw}, exp);
   endtask : pr

   // Pointer shows one edge later than the strobe
   task automatic sp(input logic [2:0] ppl, input logic [15:0] d, input logic [15:0] exp);
      u_seq.stk(ppl, d);
      @(posedge clk_sys);
      #1 chk({8'h00, stk_ptr}, {8'h00, exp});
   endtask : sp

   task automatic t_map;
      u_seq.map_set(1'b1, AMP_MODE_KERNEL, 3'd0, 16'h0001, AMP_ACC_RW);
      u_seq.map_set(1'b0, AMP_MODE_KERNEL, 3'd0, 16'h0002, AMP_ACC_RO);
      u_seq.map_set(1'b0, AMP_MODE_KERNEL, 3'd2, 16'h0003, AMP_ACC_RW);
      u_seq.map_set(1'b0, AMP_MODE_KERNEL, 3'd3, 16'h0004, AMP_ACC_RSVD);
      xf(AMP_XF_FETCH, 16'h0004, 24'hC0_0044);
      xf(AMP_XF_READ, 16'h0004, 24'h80_0084);
      xf(AMP_XF_WRITE, 16'h0004, 24'h00_0000);
      xf(AMP_XF_READ, 16'h2000, 24'h00_0000);
      xf(AMP_XF_WRITE, 16'h4010, 24'h80_00D0);
      xf(AMP_XF_READ, 16'h6000, 24'h00_0000);
   endtask : t_map

   task automatic t_priv;
      pr(AMP_OP_PSW, 16'h3000, 24'h03_3000);
      pr(AMP_OP_HALT, 16'h0000, 24'h43_3000);
      pr(AMP_OP_RESET, 16'h0000, 24'h13_3000);
      pr(AMP_OP_PSW, 16'hC000, 24'h0C_C000);
      pr(AMP_OP_HALT, 16'h0000, 24'h2C_C000);
      pr(AMP_OP_RESET, 16'h0000, 24'h0C_C000);
      pr(AMP_OP_SET_PRI, 16'h00E0, 24'h0C_C000);
      pr(AMP_OP_PSW, 16'h0000, 24'h0C_C000);
      xf(AMP_XF_FETCH, 16'h0004, 24'h40_0000);
   endtask : t_priv

   task automatic t_stack;
      sp(3'b001, 16'h1000, 16'h1000);
      sp(3'b100, 16'h0000, 16'h0FFE);
      sp(3'b100, 16'h0000, 16'h0FFC);
      sp(3'b010, 16'h0000, 16'h0FFE);
      u_seq.instr(AMP_OP_PSW, 16'h4000);
      @(posedge clk_sys);
      #1 chk({8'h00, stk_ptr}, 24'h00_0000);
      sp(3'b100, 16'h0000, 16'hFFFE);
      sp(3'b110, 16'h0000, 16'hFFFE);
   endtask : t_stack

   initial
   begin
      #200000;
      error_cnt++;
      tally_and_finish();
   end

   initial
   begin
      do_reset();
      t_map();
      t_priv();
      do_reset();
      t_stack();
      tally_and_finish();
   end
endmodule : testbench
